// File: rmb_msg_buffer.sv
`timescale 1ns/1ns
// Notes on behaviour
// R1: Only the switch-selected host link, USB or network, carries traffic.
// R2: Each response ends with one line feed.
// R3: Line feed or carriage return plus line feed both end a message.
// R4: Network traffic accepted only on fixed TCP port.
// R5: Commands queue in a 1024-byte store, handed on in arrival order.
// R6: Invalid command logs an error and skips commands up to terminator.
// R7: Response store of 1024 bytes; overflow flushes it and sets query error.
// R8: After overflow, responses up to the next terminator are discarded.
// R9: Error queue of sixteen; fifteen kept, sixteenth is overflow, rest discarded.
// R10: Hardware address is fixed prefix plus serial number, not changeable.
// R11: USB identity is fixed vendor code, product code by variant.
// R12: Errors read oldest first; each read removes the entry.
module rmb_msg_buffer #(
    parameter int          SERIAL_NUM  = 1,          // Arbitrary
    parameter logic [23:0] MAC_PREFIX  = 24'h020000, // Arbitrary
    parameter logic [15:0] USB_VID     = 16'h1234,   // Arbitrary
    parameter logic [15:0] USB_PID_ONE = 16'h0001,   // Arbitrary
    parameter logic [15:0] USB_PID_TWO = 16'h0002,   // Arbitrary
    parameter bit          DUAL_INPUT  = 1'b0
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Interface select switch
    input  wire logic        sel_lan_pin,
    output logic             sel_lan,
    // USB receive
    input  wire logic        usb_rx_valid,
    input  wire logic [7:0]  usb_rx_data,
    output logic             usb_rx_ready,
    // Network receive
    input  wire logic        lan_rx_valid,
    input  wire logic [7:0]  lan_rx_data,
    input  wire logic [15:0] lan_rx_port,
    output logic             lan_rx_ready,
    // USB transmit
    output logic             usb_tx_valid,
    output logic [7:0]       usb_tx_data,
    input  wire logic        usb_tx_ready,
    // Network transmit
    output logic             lan_tx_valid,
    output logic [7:0]       lan_tx_data,
    input  wire logic        lan_tx_ready,
    // Command bytes to executor
    output logic             cmd_valid,
    output logic [7:0]       cmd_data,
    output logic             cmd_last,
    input  wire logic        cmd_ready,
    // Responses from executor
    input  wire logic        rsp_valid,
    input  wire logic [7:0]  rsp_data,
    input  wire logic        rsp_end,
    output logic             rsp_ready,
    // Errors from executor
    input  wire logic        err_valid,
    input  wire logic [7:0]  err_code,
    input  wire logic        err_skip,
    // Error queue read and clear
    input  wire logic        err_pop,
    input  wire logic        err_clear,
    output logic             err_rd_valid,
    output logic [7:0]       err_rd_code,
    output logic [4:0]       err_count,
    // Status
    input  wire logic        qerr_clear,
    output logic             qerr,
    // Identity
    output logic [47:0]      mac_addr,
    output logic [15:0]      usb_vid,
    output logic [15:0]      usb_pid
);
    import rmb_pkg::*;
    logic        sel_s1_reg, sel_s2_reg, sel_s3_reg, sel_reg;
    logic        cr_pend_reg, lf_pend_reg, qerr_reg, err_do_pop;
    rmb_msg_e    msg_reg, msg_next;
    logic        port_ok, src_valid, cr_stall, accept;
    logic [7:0]  src_data;
    logic        in_wr_valid, in_wr_ready, in_rd_valid, in_pop, in_is_lf;
    logic [7:0]  in_wr_data, in_rd_data;
    logic        skip, drop, term, ovf, out_wr_valid, out_wr_ready, out_rd_valid, out_pop;
    logic [7:0]  out_wr_data, out_rd_data;
    logic [10:0] out_count;
    logic [7:0]  errq_reg [RMB_ERRQ_DEPTH];
    logic [3:0]  err_rd_idx_reg;
    logic [4:0]  err_count_reg;

    // ----------------------------------------------------------------
    // Switch synchroniser and identity
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_s1_reg <= RMB_SEL_RST;
            sel_s2_reg <= RMB_SEL_RST;
            sel_s3_reg <= RMB_SEL_RST;
            sel_reg    <= RMB_SEL_RST;
        end else begin
            sel_s1_reg <= sel_lan_pin;
            sel_s2_reg <= sel_s1_reg;
            sel_s3_reg <= sel_s2_reg;
            if (sel_s2_reg == sel_s3_reg) begin
                sel_reg <= sel_s3_reg; // see R1
            end
        end
    end
    assign sel_lan  = sel_reg;
    assign mac_addr = {MAC_PREFIX, SERIAL_NUM[23:0]}; // see R10
    assign usb_vid  = USB_VID; // see R11
    assign usb_pid  = DUAL_INPUT ? USB_PID_TWO : USB_PID_ONE; // see R11

    // ----------------------------------------------------------------
    // Receive path with CR-LF folding
    // ----------------------------------------------------------------
    assign port_ok   = (lan_rx_port == RMB_TCP_PORT); // see R4
    assign src_valid = sel_reg ? (lan_rx_valid && port_ok) : usb_rx_valid; // see R1
    assign src_data  = sel_reg ? lan_rx_data : usb_rx_data;
    assign cr_stall  = cr_pend_reg && src_valid && (src_data != RMB_LF); // see R3
    assign in_wr_valid = cr_stall || (src_valid && (src_data != RMB_CR)); // see R3
    assign in_wr_data  = cr_stall ? RMB_CR : src_data;
    assign accept      = src_valid && in_wr_ready && !cr_stall;
    assign usb_rx_ready = !sel_reg && in_wr_ready && !cr_stall; // see R1
    assign lan_rx_ready = sel_reg && (!port_ok || (in_wr_ready && !cr_stall)); // see R4
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cr_pend_reg <= 1'b0;
        end else if (cr_stall && in_wr_ready) begin
            cr_pend_reg <= 1'b0;
        end else if (accept) begin
            cr_pend_reg <= (src_data == RMB_CR); // see R3
        end
    end
    rmb_fifo #(.W(8), .DEPTH(RMB_IN_DEPTH)) u_in_fifo (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .flush    (1'b0),
        .wr_valid (in_wr_valid),
        .wr_data  (in_wr_data),
        .wr_ready (in_wr_ready),
        .rd_valid (in_rd_valid),
        .rd_data  (in_rd_data),
        .rd_ready (in_pop),
        .count    ()
    );

    // ----------------------------------------------------------------
    // Command hand-off and skip
    // ----------------------------------------------------------------
    assign skip      = (msg_reg == RMB_MSG_SKIP) || (msg_reg == RMB_MSG_SKIP_DROP);
    assign drop      = (msg_reg == RMB_MSG_DROP) || (msg_reg == RMB_MSG_SKIP_DROP);
    assign in_is_lf  = (in_rd_data == RMB_LF);
    assign cmd_valid = in_rd_valid && (!skip || in_is_lf); // see R5 R6
    assign cmd_data  = in_rd_data;
    assign cmd_last  = in_is_lf;
    assign in_pop    = in_rd_valid && (cmd_ready || (skip && !in_is_lf)); // see R6
    assign term      = in_pop && in_is_lf;
    always_comb begin
        logic s;
        logic d;
        s = skip;
        d = drop;
        if (term) begin
            s = 1'b0;
            d = 1'b0;
        end
        if (err_valid && err_skip) begin
            s = 1'b1; // see R6
        end
        if (ovf) begin
            d = 1'b1; // see R8
        end
        case ({d, s})
            2'b01:   msg_next = RMB_MSG_SKIP;
            2'b11:   msg_next = RMB_MSG_SKIP_DROP;
            2'b10:   msg_next = RMB_MSG_DROP;
            default: msg_next = RMB_MSG_RUN;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_reg <= RMB_MSG_RUN;
        end else begin
            msg_reg <= msg_next;
        end
    end

    // ----------------------------------------------------------------
    // Response path
    // ----------------------------------------------------------------
    assign rsp_ready    = !lf_pend_reg;
    assign out_wr_valid = !drop && (lf_pend_reg || rsp_valid); // see R8
    assign out_wr_data  = lf_pend_reg ? RMB_LF : rsp_data; // see R2
    assign ovf          = out_wr_valid && !out_wr_ready; // see R7
    assign out_pop      = out_rd_valid && (sel_reg ? lan_tx_ready : usb_tx_ready);
    assign usb_tx_valid = !sel_reg && out_rd_valid; // see R1
    assign lan_tx_valid = sel_reg && out_rd_valid;
    assign usb_tx_data  = out_rd_data;
    assign lan_tx_data  = out_rd_data;
    assign qerr         = qerr_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lf_pend_reg <= 1'b0;
        end else begin
            lf_pend_reg <= rsp_valid && rsp_ready && rsp_end; // see R2
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            qerr_reg <= 1'b0;
        end else if (ovf) begin
            qerr_reg <= 1'b1; // see R7
        end else if (qerr_clear) begin
            qerr_reg <= 1'b0;
        end
    end
    rmb_fifo #(.W(8), .DEPTH(RMB_OUT_DEPTH)) u_out_fifo (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .flush    (ovf),
        .wr_valid (out_wr_valid),
        .wr_data  (out_wr_data),
        .wr_ready (out_wr_ready),
        .rd_valid (out_rd_valid),
        .rd_data  (out_rd_data),
        .rd_ready (out_pop),
        .count    (out_count)
    );

    // ----------------------------------------------------------------
    // Error queue
    // ----------------------------------------------------------------
    assign err_do_pop   = err_pop && (err_count_reg != '0);
    assign err_rd_valid = (err_count_reg != '0);
    assign err_rd_code  = errq_reg[err_rd_idx_reg]; // see R12
    assign err_count    = err_count_reg;
    always_ff @(posedge sys_clk) begin
        if (err_valid && (err_clear || (err_count_reg < 5'(RMB_ERRQ_DEPTH)))) begin // see R9
            errq_reg[err_clear ? 4'h0 : err_rd_idx_reg + err_count_reg[3:0]] <=
                (!err_clear && err_count_reg == 5'(RMB_ERRQ_KEEP)) ? RMB_ERR_QOVF : err_code;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_rd_idx_reg <= '0;
            err_count_reg  <= '0;
        end else if (err_clear) begin
            err_rd_idx_reg <= '0;
            err_count_reg  <= err_valid ? 5'h01 : 5'h00;
        end else begin
            if (err_do_pop) begin
                err_rd_idx_reg <= err_rd_idx_reg + 1'b1; // see R12
            end
            err_count_reg <= err_count_reg - 5'(err_do_pop)
                + 5'(err_valid && (err_count_reg < 5'(RMB_ERRQ_DEPTH))); // see R9
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_overflow;
        out_wr_valid && !out_wr_ready;
    endsequence
    AST_ONE_LINK: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R1
        !(usb_rx_ready && lan_rx_ready) && !(usb_tx_valid && lan_tx_valid))
        else $error("both host links active");
    AST_LF_END: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R2
        (rsp_valid && rsp_ready && rsp_end && !drop && !ovf)
        |=> (out_wr_data == RMB_LF) && !rsp_ready)
        else $error("response not closed by line feed");
    AST_CRLF: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R3
        (cr_pend_reg && src_valid && src_data == RMB_LF)
        |-> (in_wr_data == RMB_LF) && usb_rx_ready == (!sel_reg && in_wr_ready))
        else $error("carriage return before line feed not folded");
    AST_PORT: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R4
        (sel_reg && lan_rx_valid && lan_rx_port != RMB_TCP_PORT) |-> !in_wr_valid)
        else $error("byte taken from wrong port");
    AST_IN_FULL: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R5
        !in_wr_ready |-> !usb_rx_ready && !(lan_rx_ready && port_ok))
        else $error("input accepted while store full");
    AST_SKIP: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R6
        (err_valid && err_skip && !term) |=> skip && (!cmd_valid || cmd_last))
        else $error("command passed after invalid command");
    AST_FLUSH: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R7
        s_overflow |=> (out_count == '0) && qerr_reg && drop)
        else $error("overflow did not flush store");
    AST_DROP: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R8
        (drop && !term) |=> drop)
        else $error("drop ended without terminator");
    AST_ERRQ_CAP: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R9
        (err_valid && !err_pop && !err_clear && err_count_reg == 5'(RMB_ERRQ_DEPTH))
        |=> err_count_reg == 5'(RMB_ERRQ_DEPTH))
        else $error("error queue grew past capacity");
    AST_POP: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R12
        (err_pop && err_rd_valid && !err_valid && !err_clear)
        |=> err_count_reg == $past(err_count_reg) - 5'h01)
        else $error("error read did not remove entry");
endmodule // rmb_msg_buffer

// File: rmb_pkg.sv
package rmb_pkg;

    // ----------------------------------------------------------------
    // Characters
    // ----------------------------------------------------------------
    localparam logic [7:0]  RMB_LF          = 8'h0A;
    localparam logic [7:0]  RMB_CR          = 8'h0D;

    // ----------------------------------------------------------------
    // Store sizes
    // ----------------------------------------------------------------
    localparam int          RMB_IN_DEPTH    = 1024;
    localparam int          RMB_OUT_DEPTH   = 1024;
    localparam int          RMB_ERRQ_DEPTH  = 16;
    localparam int          RMB_ERRQ_KEEP   = 15;

    // ----------------------------------------------------------------
    // Link constants
    // ----------------------------------------------------------------
    localparam logic [15:0] RMB_TCP_PORT    = 16'h13A1;
    localparam logic [7:0]  RMB_ERR_QOVF    = 8'hF0;
    localparam logic        RMB_SEL_RST     = 1'h0;

    // ----------------------------------------------------------------
    // Message state: skip after bad command, drop after overflow
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RMB_MSG_RUN       = 2'b00,
        RMB_MSG_SKIP      = 2'b01,
        RMB_MSG_SKIP_DROP = 2'b11,
        RMB_MSG_DROP      = 2'b10
    } rmb_msg_e;

endpackage

// File: rmb_fifo.sv
`timescale 1ns/1ns
module rmb_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 1024,
    parameter int AW    = $clog2(DEPTH),
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Control
    input  wire logic          flush,
    // Write side
    input  wire logic          wr_valid,
    input  wire logic [W-1:0]  wr_data,
    output logic               wr_ready,
    // Read side
    output logic               rd_valid,
    output logic [W-1:0]       rd_data,
    input  wire logic          rd_ready,
    // Fill level
    output logic [CW-1:0]      count
);
    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_idx_reg;
    logic [AW-1:0] rd_idx_reg;
    logic [CW-1:0] count_reg;
    logic          do_wr;
    logic          do_rd;

    assign wr_ready = (count_reg != CW'(DEPTH));
    assign rd_valid = (count_reg != '0);
    assign rd_data  = mem_reg[rd_idx_reg];
    assign count    = count_reg;
    assign do_wr    = wr_valid && wr_ready && !flush;
    assign do_rd    = rd_valid && rd_ready && !flush;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem_reg[wr_idx_reg] <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Pointers and level
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
            count_reg  <= '0;
        end else if (flush) begin
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_wr) begin
                wr_idx_reg <= (wr_idx_reg == AW'(DEPTH - 1)) ? '0 : wr_idx_reg + 1'b1;
            end
            if (do_rd) begin
                rd_idx_reg <= (rd_idx_reg == AW'(DEPTH - 1)) ? '0 : rd_idx_reg + 1'b1;
            end
            count_reg <= count_reg + CW'(do_wr) - CW'(do_rd);
        end
    end

endmodule // rmb_fifo

// File: rmb_host.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host controller model on the USB and network links
// ----------------------------------------------------------------
module rmb_host (
    // Clock and mode
    input  wire logic        sys_clk,
    input  wire logic        use_lan,
    input  wire logic        stall,
    // Host to device
    output logic             usb_rx_valid,
    output logic [7:0]       usb_rx_data,
    input  wire logic        usb_rx_ready,
    output logic             lan_rx_valid,
    output logic [7:0]       lan_rx_data,
    output logic [15:0]      lan_rx_port,
    input  wire logic        lan_rx_ready,
    // Device to host
    input  wire logic        usb_tx_valid,
    input  wire logic [7:0]  usb_tx_data,
    output logic             usb_tx_ready,
    input  wire logic        lan_tx_valid,
    input  wire logic [7:0]  lan_tx_data,
    output logic             lan_tx_ready
);
    logic [8:0] tx_q[$];
    int         timeouts = 0;

    initial begin
        usb_rx_valid = 1'b0;
        lan_rx_valid = 1'b0;
        usb_rx_data  = 8'h00;
        lan_rx_data  = 8'h00;
        lan_rx_port  = 16'h0000;
    end

    assign usb_tx_ready = !stall;
    assign lan_tx_ready = !stall;

    always @(posedge sys_clk) begin
        if (usb_tx_valid && usb_tx_ready) tx_q.push_back({1'b0, usb_tx_data});
        if (lan_tx_valid && lan_tx_ready) tx_q.push_back({1'b1, lan_tx_data});
    end

    // Bytes held until taken; messages end in LF or CR LF
    task automatic send(input logic [7:0] b, input logic [15:0] p);
        int k;
        usb_rx_valid <= !use_lan;
        lan_rx_valid <= use_lan;
        usb_rx_data  <= use_lan ? ~b : b;
        lan_rx_data  <= use_lan ? b : ~b;
        lan_rx_port  <= p;
        for (k = 0; k == 0 || (!(use_lan ? lan_rx_ready : usb_rx_ready) && k < 200); k++)
            @(posedge sys_clk);
        if (k >= 200) timeouts++;
    endtask

    // Valid lines drop low; data and port lines show the inverse of their last value
    task automatic idle();
        usb_rx_valid <= 1'b0;
        lan_rx_valid <= 1'b0;
        usb_rx_data  <= ~usb_rx_data;
        lan_rx_data  <= ~lan_rx_data;
        lan_rx_port  <= ~lan_rx_port;
        @(posedge sys_clk);
    endtask
endmodule // rmb_host

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import rmb_pkg::*;
    typedef struct packed {
        logic [31:0] din;
        logic [2:0]  nin;
        logic [31:0] dout;
        logic [2:0]  nout;
    } rmb_row_s;
    localparam logic [23:0] MAC_P = 24'h0A0B0C; // Arbitrary
    localparam logic [15:0] VID   = 16'hABCD;   // Arbitrary
    localparam logic [15:0] PID2  = 16'h0202;   // Arbitrary
    localparam int          SER   = 1234567;
    localparam rmb_row_s ROWS[4] = '{
        '{32'h000A4241, 3'h3, 32'h000A4241, 3'h3},
        '{32'h000A0D41, 3'h3, 32'h00000A41, 3'h2},
        '{32'h00000A0D, 3'h2, 32'h0000000A, 3'h1},
        '{32'h000A420D, 3'h3, 32'h000A420D, 3'h3}};

    logic        sys_clk, rst_n, sel_lan_pin, sel_lan, use_lan, stall;
    logic        usb_rx_valid, usb_rx_ready, lan_rx_valid, lan_rx_ready;
    logic        usb_tx_valid, usb_tx_ready, lan_tx_valid, lan_tx_ready;
    logic [7:0]  usb_rx_data, lan_rx_data, usb_tx_data, lan_tx_data;
    logic [15:0] lan_rx_port, usb_vid, usb_pid;
    logic        cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_end, rsp_ready;
    logic [7:0]  cmd_data, rsp_data, err_code, err_rd_code;
    logic        err_valid, err_skip, err_pop, err_clear, err_rd_valid, qerr_clear, qerr;
    logic [4:0]  err_count;
    logic [47:0] mac_addr;
    logic [8:0]  cmd_q[$];
    int          err_total = 0;
    int          samples_checked = 0;

    rmb_msg_buffer #(.SERIAL_NUM(SER), .MAC_PREFIX(MAC_P), .USB_VID(VID),
        .USB_PID_ONE(16'h0101), .USB_PID_TWO(PID2), .DUAL_INPUT(1'b1)) dut_u (
        .sys_clk, .rst_n, .sel_lan_pin, .sel_lan, .usb_rx_valid, .usb_rx_data,
        .usb_rx_ready, .lan_rx_valid, .lan_rx_data, .lan_rx_port, .lan_rx_ready,
        .usb_tx_valid, .usb_tx_data, .usb_tx_ready, .lan_tx_valid, .lan_tx_data,
        .lan_tx_ready, .cmd_valid, .cmd_data, .cmd_last, .cmd_ready, .rsp_valid,
        .rsp_data, .rsp_end, .rsp_ready, .err_valid, .err_code, .err_skip, .err_pop,
        .err_clear, .err_rd_valid, .err_rd_code, .err_count, .qerr_clear, .qerr,
        .mac_addr, .usb_vid, .usb_pid);

    rmb_host host_u (
        .sys_clk, .use_lan, .stall, .usb_rx_valid, .usb_rx_data, .usb_rx_ready,
        .lan_rx_valid, .lan_rx_data, .lan_rx_port, .lan_rx_ready, .usb_tx_valid,
        .usb_tx_data, .usb_tx_ready, .lan_tx_valid, .lan_tx_data, .lan_tx_ready);

    always @(posedge sys_clk) begin
        if (cmd_valid && cmd_ready) cmd_q.push_back({cmd_last, cmd_data});
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic give_verdict();
        err_total += host_u.timeouts;
        if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wait_q(input bit tx, input int n);
        int k;
        for (k = 0; k < 3000 && (tx ? host_u.tx_q.size() : cmd_q.size()) < n; k++)
            @(posedge sys_clk);
        if (k >= 3000) check(1'b0, "queue wait");
    endtask

    task automatic msg(input logic [31:0] d, input int n, input logic [15:0] p);
        for (int j = 0; j < n; j++) host_u.send(d[j*8+:8], p);
        host_u.idle();
    endtask

    task automatic rsp_put(input logic [7:0] b, input logic e);
        int k;
        rsp_valid <= 1'b1;
        rsp_data  <= b;
        rsp_end   <= e;
        for (k = 0; k == 0 || (!rsp_ready && k < 50); k++) @(posedge sys_clk);
        if (k >= 50) check(1'b0, "rsp wait");
    endtask

    task automatic rsp_idle();
        rsp_valid <= 1'b0;
        rsp_end   <= 1'b0;
        rsp_data  <= ~rsp_data;
        @(posedge sys_clk);
    endtask

    task automatic err_push(input logic [7:0] c, input logic s);
        err_valid <= 1'b1;
        err_code  <= c;
        err_skip  <= s;
        @(posedge sys_clk);
        err_valid <= 1'b0;
        err_skip  <= 1'b0;
        @(posedge sys_clk);
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        check(1'b0, "watchdog");
        give_verdict();
    end

    initial begin
        {rst_n, sel_lan_pin, use_lan, stall, rsp_valid, rsp_end, err_valid} = 7'h00;
        {err_skip, err_pop, err_clear, qerr_clear, rsp_data, err_code} = 20'h00000;
        cmd_ready = 1'b1;
        wait_n(20);
        check(!cmd_valid && !qerr && err_count === 5'h00 && sel_lan === 1'b0 &&
              usb_rx_ready && lan_rx_ready === 1'b0, "reset state");
        rst_n <= 1'b1;
        wait_n(1);
        check(mac_addr === {MAC_P, 24'(SER)}, "mac");
        check(usb_vid === VID && usb_pid === PID2, "usb id");
        foreach (ROWS[i]) begin
            cmd_q.delete();
            msg(ROWS[i].din, int'(ROWS[i].nin), RMB_TCP_PORT);
            wait_q(0, int'(ROWS[i].nout));
            wait_n(4);
            check(cmd_q.size() == int'(ROWS[i].nout), "cmd count");
            for (int j = 0; j < int'(ROWS[i].nout); j++)
                check(cmd_q[j] === {j == ROWS[i].nout - 1, ROWS[i].dout[j*8+:8]}, "cmd");
        end
        cmd_q.delete();
        cmd_ready <= 1'b0;
        for (int j = 0; j < 1200; j++) begin
            if (j == RMB_IN_DEPTH) begin
                wait_n(1);
                check(usb_rx_ready === 1'b0, "input store full");
                cmd_ready <= 1'b1;
            end
            host_u.send(8'h30 + 8'(j % 64), RMB_TCP_PORT);
        end
        msg(32'h0000000A, 1, RMB_TCP_PORT);
        wait_q(0, 1201);
        for (int j = 0; j < 1201; j++)
            check(cmd_q[j] === (j == 1200 ? 9'h10A : {1'b0, 8'h30 + 8'(j % 64)}), "long");
        cmd_q.delete();
        cmd_ready <= 1'b0;
        msg(32'h000A4241, 3, RMB_TCP_PORT);
        err_push(8'h11, 1'b1);
        cmd_ready <= 1'b1;
        wait_n(20);
        check(cmd_q.size() == 1 && cmd_q[0] === 9'h10A, "skip");
        check(err_count === 5'h01 && err_rd_code === 8'h11, "skip logged");
        msg(32'h00000A43, 2, RMB_TCP_PORT);
        wait_q(0, 3);
        check(cmd_q[1] === 9'h043, "after skip");
        err_clear <= 1'b1;
        wait_n(1);
        err_clear <= 1'b0;
        wait_n(1);
        check(err_count === 5'h00, "err clear");
        for (int j = 0; j < 17; j++) err_push(8'h20 + 8'(j), 1'b0);
        wait_n(1);
        check(err_count === 5'h10, "err count");
        for (int j = 0; j < 16; j++) begin
            check(err_rd_valid && err_rd_code === (j < 15 ? 8'h20 + 8'(j) : RMB_ERR_QOVF),
                  "err order");
            err_pop <= 1'b1;
            wait_n(1);
            err_pop <= 1'b0;
            wait_n(1);
        end
        check(err_rd_valid === 1'b0 && err_count === 5'h00, "err empty");
        stall <= 1'b1;
        rsp_put(8'h4F, 1'b0);
        rsp_put(8'h4B, 1'b1);
        rsp_idle();
        wait_n(10);
        check(host_u.tx_q.size() == 0, "stalled");
        stall <= 1'b0;
        wait_q(1, 3);
        check(host_u.tx_q[1] === 9'h04B && host_u.tx_q[2] === 9'h00A, "rsp end");
        host_u.tx_q.delete();
        stall <= 1'b1;
        for (int j = 0; j < RMB_OUT_DEPTH; j++) rsp_put(8'h61, 1'b0);
        rsp_idle();
        wait_n(1);
        check(qerr === 1'b0, "full no error");
        rsp_put(8'h62, 1'b0);
        rsp_idle();
        rsp_put(8'h58, 1'b1);
        rsp_idle();
        stall <= 1'b0;
        wait_n(20);
        check(qerr === 1'b1 && host_u.tx_q.size() == 0, "overflow");
        msg(32'h0000000A, 1, RMB_TCP_PORT);
        wait_n(5);
        rsp_put(8'h59, 1'b1);
        rsp_idle();
        wait_q(1, 2);
        check(host_u.tx_q[0] === 9'h059 && host_u.tx_q[1] === 9'h00A, "resume");
        qerr_clear <= 1'b1;
        wait_n(1);
        qerr_clear <= 1'b0;
        wait_n(1);
        check(qerr === 1'b0, "qerr clear");
        sel_lan_pin <= 1'b1;
        use_lan     <= 1'b1;
        for (int k = 0; k < 10 && sel_lan !== 1'b1; k++) @(posedge sys_clk);
        check(sel_lan === 1'b1 && !usb_rx_ready && lan_rx_ready, "select");
        cmd_q.delete();
        host_u.tx_q.delete();
        msg(32'h00000A51, 2, RMB_TCP_PORT);
        msg(32'h00000A57, 2, 16'h13A2);
        wait_n(10);
        check(cmd_q.size() == 2 && cmd_q[0] === 9'h051, "port");
        rsp_put(8'h52, 1'b1);
        rsp_idle();
        wait_q(1, 2);
        check(host_u.tx_q[0] === 9'h152 && host_u.tx_q[1] === 9'h10A, "lan tx");
        give_verdict();
    end
endmodule // tb_top
